// ===== hw/stc_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "stc_consts.vh"
// ==========================================
// Notes on behaviour
// - 16-bit up-counter in two readable, writable bytes, wrapping FFFF to 0000.
// - wrap sets the sticky overflow flag, cleared only by software.
// - overflow request leaves only while its enable bit is set.
// - control bit 7 selects buffered 16-bit or two 8-bit accesses.
// - bits 6 and 3 assign timer pairs to the five compare units.
// - bits 5-4 prescale the counting clock by 1, 2, 4 or 8.
// - bit 2 bypasses the external-clock synchroniser; ignored for internal clock.
// - bit 1 picks instruction clock or rising edges of the external clock.
// - bit 0 starts and stops counting.
// - modes: timer, synchronised counter, unsynchronised counter.
// - oscillator enabled forces its pins to inputs, direction bits read 0.
// - sibling control bit 3 enables the low-power oscillator.
// - a reset input from the compare logic clears the counter.
// - compare unit one or two in mode 1011 clears the counter on match.
// - a trigger clear never sets the overflow flag.
// - a software write wins over a simultaneous trigger clear.
module stc_timer (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [4:2]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        ext_count_clock_pin_i,
    input  wire        osc_clock_i,
    input  wire        unit_one_match_i,
    input  wire [3:0]  unit_one_mode_i,
    input  wire        unit_two_match_i,
    input  wire [3:0]  unit_two_mode_i,
    output wire        overflow_irq_o,
    output wire [4:0]  unit_uses_this_pair_o,
    output wire        osc_pins_input_o,
    output wire [15:0] count_o
);
    // ==========================================
    // registers
    reg  [7:0] counter_control;
    reg  [7:0] count_low_byte;
    reg  [7:0] count_high_byte;
    reg  [7:0] high_buffer;
    reg        overflow_flag;
    reg        overflow_irq_enable;
    reg  [7:0] sibling_timer_control;
    reg  [1:0] port_c_direction;
    reg  [1:0] insn_div;
    reg  [1:0] raw_meta;
    reg        raw_prev;
    reg        raw_seen_low;

    wire       wide_access_enable = counter_control[`STC_BIT_WIDE];
    wire       ext_sync_disable   = counter_control[`STC_BIT_NOSYNC];
    wire       clock_source_sel   = counter_control[`STC_BIT_CSRC];
    wire       count_enable       = counter_control[`STC_BIT_ON];
    wire [1:0] prescale_sel       = {counter_control[`STC_BIT_PS_HI],
                                     counter_control[`STC_BIT_PS_LO]};
    wire [1:0] time_base_assign   = {counter_control[`STC_BIT_TBA_HI],
                                     counter_control[`STC_BIT_TBA_LO]};
    wire       low_power_osc_enable = sibling_timer_control[`STC_BIT_OSCEN];

    // ==========================================
    // bus decode
    wire       req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr_b0 = req & wb_we_i & wb_sel_i[0];
    wire       rd    = req & ~wb_we_i;

    function hit;
        input [2:0] adr;
        input [2:0] idx;
        begin
            hit = (adr == idx);
        end
    endfunction

    wire wr_low  = wr_b0 & hit(wb_adr_i, `STC_IDX_LOW);
    wire wr_high = wr_b0 & hit(wb_adr_i, `STC_IDX_HIGH);
    wire wr_ctrl = wr_b0 & hit(wb_adr_i, `STC_IDX_CTRL);
    wire rd_low  = rd & hit(wb_adr_i, `STC_IDX_LOW);

    // ==========================================
    // counting clock selection
    // the oscillator and the pin share one input; oscillator wins when enabled
    wire ext_src = low_power_osc_enable ? osc_clock_i : ext_count_clock_pin_i;
    wire sync_rise;
    stc_edge_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .ext_clk_i (ext_src),
        .rise_o    (sync_rise)
    );

    // ==========================================
    // unsynchronised external path
    // unsynchronised path still needs two flops to be safe in this clock
    // domain; it has its own two flops and edge detect built like the synchroniser's,
    // so it reacts in the same cycle. true asynchronous counting is not modelled.
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            raw_meta     <= 2'h0;
            raw_prev     <= 1'b0;
            raw_seen_low <= 1'b0;
        end else begin
            raw_meta <= {raw_meta[0], ext_src};
            raw_prev <= raw_meta[1];
            if (!raw_meta[1])
                raw_seen_low <= 1'b1;
        end
    end
    wire raw_rise = raw_meta[1] & ~raw_prev & raw_seen_low;

    // ==========================================
    // instruction clock: one tick per four system clocks
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            insn_div <= 2'h0;
        else
            insn_div <= insn_div + 2'h1;
    end
    wire insn_tick = (insn_div == `STC_INSN_DIV);

    // three modes from the source and synchroniser bits
    wire ext_tick = ext_sync_disable ? raw_rise : sync_rise;
    wire src_tick = clock_source_sel ? ext_tick : insn_tick;

    wire count_tick;
    stc_prescaler u_pre (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .clear_i   (wr_low),
        .tick_i    (src_tick & count_enable),
        .sel_i     (prescale_sel),
        .tick_o    (count_tick)
    );

    // ==========================================
    // special event trigger
    wire sev_one = unit_one_match_i & (unit_one_mode_i == `STC_SEV_MODE);
    wire sev_two = unit_two_match_i & (unit_two_mode_i == `STC_SEV_MODE);
    wire sev_clr = sev_one | sev_two;

    // ==========================================
    // counter
    wire [15:0] count = {count_high_byte, count_low_byte};
    wire        wrap  = count_tick & (count == `STC_MAX);
    wire        sw_write = wr_low | (wr_high & ~wide_access_enable);
    reg  [15:0] next_count;
    always @* begin
        next_count = count;
        if (sw_write) begin
            if (wr_low)
                next_count[7:0] = wb_dat_i[7:0];
            if (wr_low & wide_access_enable)
                next_count[15:8] = high_buffer;
            else if (wr_high)
                next_count[15:8] = wb_dat_i[7:0];
        end else if (sev_clr)
            next_count = `STC_ZERO16;
        else if (count_tick)
            next_count = count + 16'h0001;
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            count_low_byte <= `STC_BYTE_ZERO;
        else
            count_low_byte <= next_count[7:0];
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            count_high_byte <= `STC_BYTE_ZERO;
        else
            count_high_byte <= next_count[15:8];
    end

    // the buffer lets software see or set both bytes without a torn value
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            high_buffer <= `STC_BYTE_ZERO;
        else if (wr_high & wide_access_enable)
            high_buffer <= wb_dat_i[7:0];
        else if (rd_low & wide_access_enable)
            high_buffer <= count_high_byte;
    end

    // ==========================================
    // control, flag, enable registers
    wire wr_flag  = wr_b0 & hit(wb_adr_i, `STC_IDX_FLAG);
    wire wr_irqen = wr_b0 & hit(wb_adr_i, `STC_IDX_IRQEN);
    wire wr_sib   = wr_b0 & hit(wb_adr_i, `STC_IDX_SIBLING);
    wire wr_dir   = wr_b0 & hit(wb_adr_i, `STC_IDX_PORTDIR);

    // ack one cycle after the request; req masks it so no double take
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req;
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            counter_control <= `STC_CTRL_RST;
        else if (wr_ctrl)
            counter_control <= wb_dat_i[7:0];
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            overflow_irq_enable <= 1'b0;
        else if (wr_irqen)
            overflow_irq_enable <= wb_dat_i[`STC_BIT_OVF];
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            sibling_timer_control <= `STC_BYTE_ZERO;
        else if (wr_sib)
            sibling_timer_control <= wb_dat_i[7:0];
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            port_c_direction <= `STC_DIR_RST;
        else if (wr_dir)
            port_c_direction <= wb_dat_i[1:0];
    end

    // a wrap only, never a trigger clear; set beats software clear
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            overflow_flag <= 1'b0;
        else if (wrap & ~sw_write & ~sev_clr)
            overflow_flag <= 1'b1;
        else if (wr_flag)
            overflow_flag <= wb_dat_i[`STC_BIT_OVF];
    end

    // ==========================================
    // read data
    reg [31:0] next_rd_data;
    always @* begin
        next_rd_data = `STC_WORD_ZERO;
        case (wb_adr_i)
            `STC_IDX_LOW:     next_rd_data[7:0] = count_low_byte;
            `STC_IDX_HIGH:    next_rd_data[7:0] = wide_access_enable ? high_buffer
                                                                     : count_high_byte;
            `STC_IDX_CTRL:    next_rd_data[7:0] = counter_control;
            `STC_IDX_FLAG:    next_rd_data[`STC_BIT_OVF] = overflow_flag;
            `STC_IDX_IRQEN:   next_rd_data[`STC_BIT_OVF] = overflow_irq_enable;
            `STC_IDX_SIBLING: next_rd_data[7:0] = sibling_timer_control;
            // forced inputs read back as zero while oscillator runs
            `STC_IDX_PORTDIR: next_rd_data[1:0] = low_power_osc_enable ? 2'h0
                                                                       : port_c_direction;
            default:          next_rd_data = `STC_WORD_ZERO;
        endcase
    end

    // read data holds until the next read so a slow master still sees it
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            wb_dat_o <= `STC_WORD_ZERO;
        else if (rd)
            wb_dat_o <= next_rd_data;
    end

    // ==========================================
    // outputs
    assign overflow_irq_o   = overflow_flag & overflow_irq_enable;
    assign osc_pins_input_o = low_power_osc_enable;
    assign count_o          = count;

    // unit k (0..4) uses this pair when its index is at or above the threshold
    function pair_for_unit;
        input [1:0] sel;
        input integer unit;
        begin
            case (sel)
                2'h3:    pair_for_unit = 1'b1;
                2'h2:    pair_for_unit = (unit >= 2);
                2'h1:    pair_for_unit = (unit >= 1);
                default: pair_for_unit = 1'b0;
            endcase
        end
    endfunction

    genvar k;
    generate
        for (k = 0; k < `STC_UNITS; k = k + 1) begin : g_tb
            assign unit_uses_this_pair_o[k] = pair_for_unit(time_base_assign, k);
        end
    endgenerate
endmodule
`default_nettype wire

// ===== hw/stc_consts.vh
`ifndef STC_CONSTS_VH
`define STC_CONSTS_VH
// ==========================================
// register word addresses (byte address = index * 4)
`define STC_IDX_LOW      3'h0
`define STC_IDX_HIGH     3'h1
`define STC_IDX_CTRL     3'h2
`define STC_IDX_FLAG     3'h3
`define STC_IDX_IRQEN    3'h4
`define STC_IDX_SIBLING  3'h5
`define STC_IDX_PORTDIR  3'h6
// ==========================================
// counter control fields, then other register bits and constants
`define STC_BIT_WIDE     7
`define STC_BIT_TBA_HI   6
`define STC_BIT_PS_HI    5
`define STC_BIT_PS_LO    4
`define STC_BIT_TBA_LO   3
`define STC_BIT_NOSYNC   2
`define STC_BIT_CSRC     1
`define STC_BIT_ON       0
`define STC_BIT_OVF      1
`define STC_BIT_OSCEN    3
`define STC_CTRL_RST     8'h00
`define STC_DIR_RST      2'h3
`define STC_WORD_ZERO    32'h00000000
`define STC_BYTE_ZERO    8'h00
`define STC_MAX          16'hFFFF
`define STC_ZERO16       16'h0000
`define STC_SEV_MODE     4'hB
`define STC_INSN_DIV     2'h3
`define STC_UNITS        5
`endif

// ===== hw/stc_edge_sync.v
`timescale 1ns/100ps
`default_nettype none
`include "stc_consts.vh"
// ==========================================
// external clock: two-flop sync and rising-edge pulse after a seen low
module stc_edge_sync (
    input  wire       ref_clk_i,
    input  wire       rst_i,
    input  wire       ext_clk_i,
    output wire       rise_o
);
    reg meta;
    reg sync;
    reg prev;
    reg seen_low;
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta     <= 1'b0;
            sync     <= 1'b0;
            prev     <= 1'b0;
            seen_low <= 1'b0;
        end else begin
            meta <= ext_clk_i;
            sync <= meta;
            prev <= sync;
            if (!sync)
                seen_low <= 1'b1;
        end
    end
    // first rising edge only counts after a falling/low level has been seen
    assign rise_o = sync & ~prev & seen_low;
endmodule
`default_nettype wire

// ===== hw/stc_prescaler.v
`timescale 1ns/100ps
`default_nettype none
`include "stc_consts.vh"
// ==========================================
// 1/2/4/8 prescaler on a tick stream
module stc_prescaler (
    input  wire       ref_clk_i,
    input  wire       rst_i,
    input  wire       clear_i,
    input  wire       tick_i,
    input  wire [1:0] sel_i,
    output wire       tick_o
);
    reg  [2:0] cnt;
    reg  [2:0] mask;
    always @* begin
        case (sel_i)
            2'h0:    mask = 3'h0;
            2'h1:    mask = 3'h1;
            2'h2:    mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            cnt <= 3'h0;
        else if (clear_i)
            cnt <= 3'h0;
        else if (tick_i)
            cnt <= cnt + 3'h1;
    end
    assign tick_o = tick_i & ((cnt & mask) == mask);
endmodule
`default_nettype wire

// ===== tb/stc_ext_clock_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// far-side clock source: still and low between bursts so rises can be counted
module stc_ext_clock_model #(
    parameter int HALF_NS = 130
) (
    input  wire logic run_i,
    output var  logic clk_o,
    output var  int   rises_o
);
    initial clk_o = 1'b0;
    initial rises_o = 0;
    // a burst always ends low, so each rise follows a seen low
    always begin
        wait (run_i === 1'b1);
        #HALF_NS clk_o = 1'b1;
        rises_o = rises_o + 1;
        #HALF_NS clk_o = 1'b0;
    end
endmodule
`default_nettype wire

// ===== tb/stc_timer_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "stc_consts.vh"
// ==========================================
// port-level checks
module stc_timer_properties (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [4:2]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        unit_one_match_i,
    input wire logic [3:0]  unit_one_mode_i,
    input wire logic        unit_two_match_i,
    input wire logic [3:0]  unit_two_mode_i,
    input wire logic        overflow_irq_o,
    input wire logic [4:0]  unit_uses_this_pair_o,
    input wire logic        osc_pins_input_o,
    input wire logic [15:0] count_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire logic req = wb_cyc_i & wb_stb_i & !wb_ack_o;
    wire logic wr = req & wb_we_i;
    wire logic trig = unit_one_match_i & (unit_one_mode_i == `STC_SEV_MODE)
                    | unit_two_match_i & (unit_two_mode_i == `STC_SEV_MODE);
    a_count_step: assert property ($changed(count_o) && !$past(wr) && !$past(trig)
        |-> count_o == $past(count_o) + 16'h0001) else $error("count moved by more than one");
    a_wrap_flag: assert property ($rose(overflow_irq_o)
        |-> $past(count_o) == `STC_MAX || $past(wr)) else $error("request without wrap");
    a_flag_sticky: assert property ($fell(overflow_irq_o) |-> $past(wr))
        else $error("request dropped without software");
    a_trig_clear: assert property (trig && !wr |=> count_o == `STC_ZERO16)
        else $error("trigger did not clear count");
    a_trig_no_flag: assert property (trig && !wr && !overflow_irq_o |=> !overflow_irq_o)
        else $error("trigger clear raised request");
    a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 3'h7 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_pair_legal: assert property (unit_uses_this_pair_o inside {5'h00, 5'h1C, 5'h1E, 5'h1F})
        else $error("illegal pair map");
    a_osc_by_write: assert property ($changed(osc_pins_input_o)
        |-> $past(wr) && $past(wb_adr_i) == `STC_IDX_SIBLING) else $error("osc pins moved alone");
    cover property (trig);
    cover property ($rose(overflow_irq_o));
    cover property (wr && wb_adr_i == `STC_IDX_HIGH);
endmodule
bind stc_timer stc_timer_properties u_props (.*);
`default_nettype wire

// ===== tb/sixteen_bit_timer_counter_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "stc_consts.vh"
module sixteen_bit_timer_counter_test;
    logic        ref_clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0, unit_one_match_i = 1'b0, unit_two_match_i = 1'b0;
    logic [4:2]  wb_adr_i = 3'h0;
    logic [3:0]  wb_sel_i = 4'hF, unit_one_mode_i = 4'h0, unit_two_mode_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic        pin_run = 1'b0, osc_run = 1'b0;
    wire logic [31:0] wb_dat_o;
    wire logic [15:0] count_o;
    wire logic [4:0]  unit_uses_this_pair_o;
    wire logic wb_ack_o, overflow_irq_o, osc_pins_input_o, ext_count_clock_pin_i, osc_clock_i;
    int          num_errors = 0, compares = 0, seed = 28, pin_n, osc_n, r0, c0;
    logic [31:0] expq[$];
    logic [4:0]  pmap [4] = '{5'h00, 5'h1E, 5'h1C, 5'h1F};
    always #25 ref_clk_i = ~ref_clk_i;
    stc_timer uut (.*);
    stc_ext_clock_model #(.HALF_NS(130)) pin_src (.run_i(pin_run),
        .clk_o(ext_count_clock_pin_i), .rises_o(pin_n));
    // oscillator at its 200 kHz ceiling; system clock stays on ref_clk_i
    stc_ext_clock_model #(.HALF_NS(2500)) osc_src (.run_i(osc_run),
        .clk_o(osc_clock_i), .rises_o(osc_n));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) num_errors++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic fire(input logic u, input logic [3:0] md);
        @(posedge ref_clk_i);
        unit_one_mode_i <= md;
        unit_two_mode_i <= md;
        unit_one_match_i <= !u;
        unit_two_match_i <= u;
        @(posedge ref_clk_i);
        unit_one_match_i <= 1'b0;
        unit_two_match_i <= 1'b0;
    endtask
    // read data is judged at the edge that samples ack
    always @(posedge ref_clk_i)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0)
            chk("read data", wb_dat_o, expq.pop_front());
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(`STC_IDX_CTRL, 32'h0);
        rd(`STC_IDX_PORTDIR, 32'h3);
        rd(3'h7, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `STC_IDX_CTRL, {25'h0, i[1], 2'h0, i[0], 3'h0});
            rd(`STC_IDX_CTRL, {25'h0, i[1], 2'h0, i[0], 3'h0});
            chk("pair map", unit_uses_this_pair_o, pmap[i]);
        end
        $display("test pairs done");
        for (int ps = 0; ps < 5; ps++) begin
            r0 = $random(seed);
            bus(1'b1, `STC_IDX_HIGH, 32'h0);
            bus(1'b1, `STC_IDX_LOW, r0 & 32'hFF);
            // bit2 random: ignored with the internal clock; last pass is stopped
            bus(1'b1, `STC_IDX_CTRL, {26'h0, ps[1:0], 1'b0, r0[8], 1'b0, ps < 4});
            @(negedge ref_clk_i);
            c0 = count_o;
            repeat (32 << ps[1:0]) @(negedge ref_clk_i);
            chk("prescaled count", count_o - c0, ps < 4 ? 8 : 0);
        end
        $display("test prescale done");
        bus(1'b1, `STC_IDX_IRQEN, 32'h2);
        bus(1'b1, `STC_IDX_HIGH, 32'hFF);
        bus(1'b1, `STC_IDX_LOW, 32'hFE);
        bus(1'b1, `STC_IDX_CTRL, 32'h1);
        repeat (16) @(negedge ref_clk_i);
        chk("wrap request", overflow_irq_o, 1'b1);
        chk("wrap high", count_o[15:8], 32'h0);
        bus(1'b1, `STC_IDX_CTRL, 32'h0);
        rd(`STC_IDX_FLAG, 32'h2);
        bus(1'b1, `STC_IDX_IRQEN, 32'h0);
        chk("masked request", overflow_irq_o, 1'b0);
        bus(1'b1, `STC_IDX_FLAG, 32'h0);
        rd(`STC_IDX_FLAG, 32'h0);
        $display("test overflow done");
        bus(1'b1, `STC_IDX_CTRL, 32'h80);
        bus(1'b1, `STC_IDX_HIGH, 32'h12);
        bus(1'b1, `STC_IDX_LOW, 32'h34);
        bus(1'b1, `STC_IDX_HIGH, 32'h56);
        rd(`STC_IDX_LOW, 32'h34);
        rd(`STC_IDX_HIGH, 32'h12);
        $display("test wide done");
        // timer mode, stopped, while the trigger clear is used
        bus(1'b1, `STC_IDX_CTRL, 32'h0);
        bus(1'b1, `STC_IDX_IRQEN, 32'h2);
        bus(1'b1, `STC_IDX_HIGH, 32'hFF);
        bus(1'b1, `STC_IDX_LOW, 32'hFF);
        fire(1'b0, `STC_SEV_MODE);
        bus(1'b1, `STC_IDX_LOW, 32'h05);
        chk("irq after trigger", overflow_irq_o, 1'b0);
        fire(1'b1, 4'h2);
        rd(`STC_IDX_LOW, 32'h05);
        fire(1'b1, `STC_SEV_MODE);
        rd(`STC_IDX_LOW, 32'h00);
        fork
            bus(1'b1, `STC_IDX_LOW, 32'h77);
            fire(1'b0, `STC_SEV_MODE);
        join
        rd(`STC_IDX_LOW, 32'h77);
        $display("test trigger done");
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, `STC_IDX_SIBLING, k == 2 ? 32'h8 : 32'h0);
            bus(1'b1, `STC_IDX_CTRL, k == 1 ? 32'h7 : 32'h3);
            @(negedge ref_clk_i);
            c0 = count_o;
            r0 = pin_n + osc_n;
            osc_run <= k == 2;
            pin_run <= k != 2;
            repeat (k == 2 ? 600 : 60) @(negedge ref_clk_i);
            pin_run <= 1'b0;
            osc_run <= 1'b0;
            repeat (k == 2 ? 150 : 20) @(negedge ref_clk_i);
            chk("external count", count_o - c0, pin_n + osc_n - r0);
        end
        chk("osc pins input", osc_pins_input_o, 1'b1);
        rd(`STC_IDX_PORTDIR, 32'h0);
        $display("test external done");
        end_of_test();
    end
endmodule
`default_nettype wire
